//--- pkg/mgpp_pkg.sv
package mgpp_pkg;
  localparam logic [15:0] ADDR_DATA2  = 16'hFF02;
  localparam logic [15:0] ADDR_DATA3  = 16'hFF03;
  localparam logic [15:0] ADDR_DATA4  = 16'hFF04;
  localparam logic [15:0] ADDR_DATA12 = 16'hFF0C;
  localparam logic [15:0] ADDR_DATA13 = 16'hFF0D;
  localparam logic [15:0] ADDR_DIR2   = 16'hFF22;
  localparam logic [15:0] ADDR_DIR3   = 16'hFF23;
  localparam logic [15:0] ADDR_DIR4   = 16'hFF24;
  localparam logic [15:0] ADDR_DIR12  = 16'hFF2C;
  localparam logic [15:0] ADDR_PU2    = 16'hFF32;
  localparam logic [15:0] ADDR_PU3    = 16'hFF33;
  localparam logic [15:0] ADDR_PU4    = 16'hFF34;
  localparam logic [15:0] ADDR_PORT_TWELVE_PULLUP_ENABLE   = 16'hFF3C;
  localparam logic [15:0] ADDR_ANA2   = 16'hFF84;
  localparam logic [7:0]  MASK2       = 8'h0F;
  localparam logic [7:0]  MASK3       = 8'h03;
  localparam logic [7:0]  MASK4       = 8'h3F;
  localparam logic [7:0]  MASK12      = 8'h0E;
  localparam logic [7:0]  MASK13      = 8'h01;
  localparam logic [7:0]  MASK_PORT_TWELVE_PULLUP_ENABLE   = 8'h08;
  localparam logic [7:0]  DIR_RESET   = 8'hFF;
  localparam logic [7:0]  DATA_RESET  = 8'h00;
  localparam logic [1:0]  CLK_HSI     = 2'h0;
  localparam logic [1:0]  CLK_XTAL    = 2'h1;
  localparam logic [1:0]  CLK_EXT     = 2'h2;
  localparam logic [2:0]  OWN_XTAL    = 3'h3;
  localparam logic [2:0]  OWN_EXT     = 3'h1;

  typedef enum logic {ST_OPT_WAIT, ST_RUN} mgpp_state_type;

  // Byte write, or single-bit write of bit idx taken from wdata
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wdata,
                                       input logic bit_op, input logic [2:0] idx);
    logic [7:0] res;
    res = old;
    if (bit_op) begin
      res[idx] = wdata[idx];
    end else begin
      res = wdata;
    end
    return res;
  endfunction : merge
endpackage : mgpp_pkg

//--- logic/mgpp_sync.sv
`timescale 1ns/10ps
module mgpp_sync #(
  parameter int W = 16
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1_reg <= '0;
      sync_out   <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end
endmodule : mgpp_sync

//--- logic/mgpp_pin_cell.sv
`timescale 1ns/10ps
module mgpp_pin_cell #(
  parameter int           W       = 4,
  parameter logic [W-1:0] PU_MASK = '1
) (
  input  wire logic [W-1:0] dir,
  input  wire logic [W-1:0] latch,
  input  wire logic [W-1:0] owned,
  input  wire logic [W-1:0] alt_en,
  input  wire logic [W-1:0] alt_val,
  input  wire logic [W-1:0] pu_en,
  input  wire logic [W-1:0] pin_sync,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe,
  output logic      [W-1:0] pin_pullup,
  output logic      [W-1:0] rd_val
);
  // Buffer on only in output mode and when nothing else owns the pin
  assign pin_oe     = ~dir & ~owned; // R15 R24
  assign pin_out    = (alt_en & alt_val) | (~alt_en & latch); // R24
  assign pin_pullup = dir & pu_en & ~owned & PU_MASK; // R2 R9
  assign rd_val     = ((dir & pin_sync) | (~dir & latch)) & ~owned; // R19
endmodule : mgpp_pin_cell

//--- logic/mgpp_ports.sv
`timescale 1ns/10ps
// How it works
// R1: Port two is four bidirectional bits with latch and per-bit direction.
// R2: Pull-up on ports two, three, four only in input mode with enable set.
// R3: Reset puts every bidirectional bit of ports two, three, four, twelve in input.
// R4: Port three bits zero, one are bidirectional, shared with timer and interrupts.
// R5: Input-only bit shares the reset pin; option picks function; reset at power-on.
// R6: Reset pin configured as input port no longer resets the device.
// R7: Option read after reset release; low reset pin before that holds reset.
// R8: Port four is six bidirectional bits, shared with interrupt, serial, timer.
// R9: Port twelve is three bidirectional bits; pull-up only on bit three, input mode.
// R10: Internal oscillator selected: port twelve bits one, two are ordinary pins.
// R11: Crystal oscillator selected: port twelve bits one, two unavailable.
// R12: External clock: bit one carries clock, bit two stays a port pin.
// R13: Port thirteen is one output-only bit, low while reset is asserted.
// R14: Direction registers reset to all ones.
// R15: Direction 0 means output buffer on, 1 means input, buffer off.
// R16: Direction registers accept single-bit and whole-byte writes.
// R17: Interrupt-shared pin level change raises its request even in output mode.
// R18: Seventeen pins: fifteen bidirectional, one input-only, one output-only.
// R19: Data read gives pin level in input mode, latch in output mode.
// R20: Write in input mode updates the latch but leaves the pin alone.
// R21: Port two analog select: 0 port, 1 converter input, pin unusable.
// R22: Reset clears all output latches to zero.
// R23: Unimplemented direction bits read one and ignore writes.
// R24: Pin driven from latch only in output mode and not otherwise owned.
module mgpp_ports (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic        bus_bit_op,
  input  wire logic [2:0]  bus_bit_idx,
  output logic      [7:0]  bus_rdata,
  input  wire logic        opt_reset_is_port,
  input  wire logic [1:0]  opt_clk_sel,
  output logic             core_reset_n,
  input  wire logic [3:0]  p2_pin_in,
  output logic      [3:0]  p2_pin_out,
  output logic      [3:0]  p2_pin_oe,
  output logic      [3:0]  p2_pullup,
  output logic      [3:0]  p2_analog_en,
  input  wire logic [1:0]  p3_pin_in,
  output logic      [1:0]  p3_pin_out,
  output logic      [1:0]  p3_pin_oe,
  output logic      [1:0]  p3_pullup,
  input  wire logic [1:0]  alt3_en,
  input  wire logic [1:0]  alt3_val,
  input  wire logic [5:0]  p4_pin_in,
  output logic      [5:0]  p4_pin_out,
  output logic      [5:0]  p4_pin_oe,
  output logic      [5:0]  p4_pullup,
  input  wire logic [5:0]  alt4_en,
  input  wire logic [5:0]  alt4_val,
  input  wire logic [3:1]  p12_pin_in,
  output logic      [3:1]  p12_pin_out,
  output logic      [3:1]  p12_pin_oe,
  output logic      [3:1]  p12_pullup,
  output logic      [1:0]  osc_mode,
  input  wire logic        reset_shared_pin,
  output logic             output_only_port_bit,
  output logic      [2:0]  ext_irq_req
);
  logic [7:0]  port_two_direction_reg;
  logic [7:0]  port_three_direction_reg;
  logic [7:0]  port_four_direction_reg;
  logic [7:0]  port_twelve_direction_reg;
  logic [7:0]  data2_reg;
  logic [7:0]  data3_reg;
  logic [7:0]  data4_reg;
  logic [7:0]  data12_reg;
  logic [7:0]  data13_reg;
  logic [7:0]  port_two_pullup_enable_reg;
  logic [7:0]  port_three_pullup_enable_reg;
  logic [7:0]  port_four_pullup_enable_reg;
  logic [7:0]  port_twelve_pullup_enable_reg;
  logic [7:0]  port_two_analog_select_reg;
  logic [15:0] sync_all;
  logic [3:0]  p2_sync;
  logic [1:0]  p3_sync;
  logic [5:0]  p4_sync;
  logic [2:0]  p12_sync;
  logic        rst_pin_sync;
  logic [3:0]  rd2;
  logic [1:0]  rd3;
  logic [5:0]  rd4;
  logic [2:0]  rd12;
  logic [2:0]  osc_owned;
  logic [2:0]  irq_prev_reg;
  logic [2:0]  irq_now;
  logic        reset_is_port_reg;
  logic [1:0]  clk_sel_reg;
  logic        core_reset_n_reg;
  logic        p13_out_reg;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic [2:0]  irq_reg;
  mgpp_pkg::mgpp_state_type state_reg;

  function automatic logic hit(input logic [15:0] a);
    return bus_wr && (bus_addr == a);
  endfunction : hit

  function automatic logic [7:0] wval(input logic [7:0] old);
    return mgpp_pkg::merge(old, bus_wdata, bus_bit_op, bus_bit_idx);
  endfunction : wval

  // All pins pass two flops before use
  mgpp_sync #(
    .W(16)
  ) u_sync (
    .clock   (clock),
    .rst_n   (rst_n),
    .async_in({reset_shared_pin, p12_pin_in, p4_pin_in, p3_pin_in, p2_pin_in}), // R18
    .sync_out(sync_all)
  );

  assign p2_sync      = sync_all[3:0];
  assign p3_sync      = sync_all[5:4];
  assign p4_sync      = sync_all[11:6];
  assign p12_sync     = sync_all[14:12];
  assign rst_pin_sync = sync_all[15];

  // Direction registers, unimplemented bits forced to one
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_two_direction_reg    <= mgpp_pkg::DIR_RESET; // R3 R14
      port_three_direction_reg  <= mgpp_pkg::DIR_RESET; // R3 R14
      port_four_direction_reg   <= mgpp_pkg::DIR_RESET; // R3 R14
      port_twelve_direction_reg <= mgpp_pkg::DIR_RESET; // R3 R14
    end else begin
      if (hit(mgpp_pkg::ADDR_DIR2)) begin
        port_two_direction_reg <= wval(port_two_direction_reg) | ~mgpp_pkg::MASK2; // R16 R23
      end
      if (hit(mgpp_pkg::ADDR_DIR3)) begin
        port_three_direction_reg <= wval(port_three_direction_reg) | ~mgpp_pkg::MASK3; // R16 R23
      end
      if (hit(mgpp_pkg::ADDR_DIR4)) begin
        port_four_direction_reg <= wval(port_four_direction_reg) | ~mgpp_pkg::MASK4; // R16 R23
      end
      if (hit(mgpp_pkg::ADDR_DIR12)) begin
        port_twelve_direction_reg <= wval(port_twelve_direction_reg) | ~mgpp_pkg::MASK12; // R16
      end
    end
  end

  // Output latches, written in either mode
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data2_reg  <= mgpp_pkg::DATA_RESET; // R22
      data3_reg  <= mgpp_pkg::DATA_RESET; // R22
      data4_reg  <= mgpp_pkg::DATA_RESET; // R22
      data12_reg <= mgpp_pkg::DATA_RESET; // R22
      data13_reg <= mgpp_pkg::DATA_RESET; // R22
    end else begin
      if (hit(mgpp_pkg::ADDR_DATA2)) begin
        data2_reg <= wval(data2_reg) & mgpp_pkg::MASK2; // R20
      end
      if (hit(mgpp_pkg::ADDR_DATA3)) begin
        data3_reg <= wval(data3_reg) & mgpp_pkg::MASK3; // R20
      end
      if (hit(mgpp_pkg::ADDR_DATA4)) begin
        data4_reg <= wval(data4_reg) & mgpp_pkg::MASK4; // R20
      end
      if (hit(mgpp_pkg::ADDR_DATA12)) begin
        data12_reg <= wval(data12_reg) & mgpp_pkg::MASK12; // R20
      end
      if (hit(mgpp_pkg::ADDR_DATA13)) begin
        data13_reg <= wval(data13_reg) & mgpp_pkg::MASK13;
      end
    end
  end

  // Pull-up enables and analog select
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_two_pullup_enable_reg    <= mgpp_pkg::DATA_RESET;
      port_three_pullup_enable_reg  <= mgpp_pkg::DATA_RESET;
      port_four_pullup_enable_reg   <= mgpp_pkg::DATA_RESET;
      port_twelve_pullup_enable_reg <= mgpp_pkg::DATA_RESET;
      port_two_analog_select_reg    <= mgpp_pkg::DATA_RESET;
    end else begin
      if (hit(mgpp_pkg::ADDR_PU2)) begin
        port_two_pullup_enable_reg <= wval(port_two_pullup_enable_reg) & mgpp_pkg::MASK2;
      end
      if (hit(mgpp_pkg::ADDR_PU3)) begin
        port_three_pullup_enable_reg <= wval(port_three_pullup_enable_reg) & mgpp_pkg::MASK3;
      end
      if (hit(mgpp_pkg::ADDR_PU4)) begin
        port_four_pullup_enable_reg <= wval(port_four_pullup_enable_reg) & mgpp_pkg::MASK4;
      end
      if (hit(mgpp_pkg::ADDR_PORT_TWELVE_PULLUP_ENABLE)) begin
        port_twelve_pullup_enable_reg <= wval(port_twelve_pullup_enable_reg)
                                         & mgpp_pkg::MASK_PORT_TWELVE_PULLUP_ENABLE; // R9
      end
      if (hit(mgpp_pkg::ADDR_ANA2)) begin
        port_two_analog_select_reg <= wval(port_two_analog_select_reg) & mgpp_pkg::MASK2; // R21
      end
    end
  end

  // Option read after release; low reset pin holds the core in reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg         <= mgpp_pkg::ST_OPT_WAIT;
      reset_is_port_reg <= 1'b0;
      clk_sel_reg       <= mgpp_pkg::CLK_HSI;
      core_reset_n_reg  <= 1'b0;
    end else begin
      unique case (state_reg)
        mgpp_pkg::ST_OPT_WAIT: begin
          if (rst_pin_sync) begin // R5 R7
            reset_is_port_reg <= opt_reset_is_port;
            clk_sel_reg       <= opt_clk_sel;
            core_reset_n_reg  <= 1'b1;
            state_reg         <= mgpp_pkg::ST_RUN;
          end
        end
        mgpp_pkg::ST_RUN: begin
          if (!reset_is_port_reg && !rst_pin_sync) begin // R6
            core_reset_n_reg <= 1'b0;
            state_reg        <= mgpp_pkg::ST_OPT_WAIT;
          end
        end
      endcase
    end
  end

  assign core_reset_n = core_reset_n_reg;
  assign osc_mode     = clk_sel_reg;

  always_comb begin
    unique case (clk_sel_reg)
      mgpp_pkg::CLK_XTAL: osc_owned = mgpp_pkg::OWN_XTAL; // R11
      mgpp_pkg::CLK_EXT:  osc_owned = mgpp_pkg::OWN_EXT; // R12
      default:            osc_owned = 3'h0; // R10
    endcase
  end

  mgpp_pin_cell #(
    .W(4),
    .PU_MASK(4'hF)
  ) u_p2 (
    .dir       (port_two_direction_reg[3:0]), // R1
    .latch     (data2_reg[3:0]),
    .owned     (port_two_analog_select_reg[3:0]), // R21
    .alt_en    (4'h0),
    .alt_val   (4'h0),
    .pu_en     (port_two_pullup_enable_reg[3:0]),
    .pin_sync  (p2_sync),
    .pin_out   (p2_pin_out),
    .pin_oe    (p2_pin_oe),
    .pin_pullup(p2_pullup),
    .rd_val    (rd2)
  );

  assign p2_analog_en = port_two_analog_select_reg[3:0];

  mgpp_pin_cell #(
    .W(2),
    .PU_MASK(2'h3)
  ) u_p3 (
    .dir       (port_three_direction_reg[1:0]), // R4
    .latch     (data3_reg[1:0]),
    .owned     (2'h0),
    .alt_en    (alt3_en),
    .alt_val   (alt3_val),
    .pu_en     (port_three_pullup_enable_reg[1:0]),
    .pin_sync  (p3_sync),
    .pin_out   (p3_pin_out),
    .pin_oe    (p3_pin_oe),
    .pin_pullup(p3_pullup),
    .rd_val    (rd3)
  );

  mgpp_pin_cell #(
    .W(6),
    .PU_MASK(6'h3F)
  ) u_p4 (
    .dir       (port_four_direction_reg[5:0]), // R8
    .latch     (data4_reg[5:0]),
    .owned     (6'h00),
    .alt_en    (alt4_en),
    .alt_val   (alt4_val),
    .pu_en     (port_four_pullup_enable_reg[5:0]),
    .pin_sync  (p4_sync),
    .pin_out   (p4_pin_out),
    .pin_oe    (p4_pin_oe),
    .pin_pullup(p4_pullup),
    .rd_val    (rd4)
  );

  mgpp_pin_cell #(
    .W(3),
    .PU_MASK(3'h4)
  ) u_p12 (
    .dir       (port_twelve_direction_reg[3:1]), // R9
    .latch     (data12_reg[3:1]),
    .owned     (osc_owned),
    .alt_en    (3'h0),
    .alt_val   (3'h0),
    .pu_en     (port_twelve_pullup_enable_reg[3:1]),
    .pin_sync  (p12_sync),
    .pin_out   (p12_pin_out),
    .pin_oe    (p12_pin_oe),
    .pin_pullup(p12_pullup),
    .rd_val    (rd12)
  );

  // Output-only bit is registered: it goes low one cycle after the core is put in reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      p13_out_reg <= 1'b0; // R13
    end else begin
      p13_out_reg <= core_reset_n_reg & data13_reg[0]; // R13
    end
  end

  assign output_only_port_bit = p13_out_reg;

  // Level change on interrupt-shared pins, whatever the direction
  assign irq_now = {p4_sync[3], p3_sync[1], p3_sync[0]};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_prev_reg <= 3'h0;
      irq_reg      <= 3'h0;
    end else begin
      irq_prev_reg <= irq_now;
      irq_reg      <= irq_now ^ irq_prev_reg; // R17
    end
  end

  assign ext_irq_req = irq_reg;

  always_comb begin
    unique case (bus_addr)
      mgpp_pkg::ADDR_DATA2:  rdata_next = {4'h0, rd2}; // R19
      mgpp_pkg::ADDR_DATA3:  rdata_next = {3'h0, rst_pin_sync, 2'h0, rd3}; // R5 R19
      mgpp_pkg::ADDR_DATA4:  rdata_next = {2'h0, rd4}; // R19
      mgpp_pkg::ADDR_DATA12: rdata_next = {4'h0, rd12, 1'b0}; // R19
      mgpp_pkg::ADDR_DATA13: rdata_next = data13_reg;
      mgpp_pkg::ADDR_DIR2:   rdata_next = port_two_direction_reg;
      mgpp_pkg::ADDR_DIR3:   rdata_next = port_three_direction_reg;
      mgpp_pkg::ADDR_DIR4:   rdata_next = port_four_direction_reg;
      mgpp_pkg::ADDR_DIR12:  rdata_next = port_twelve_direction_reg;
      mgpp_pkg::ADDR_PU2:    rdata_next = port_two_pullup_enable_reg;
      mgpp_pkg::ADDR_PU3:    rdata_next = port_three_pullup_enable_reg;
      mgpp_pkg::ADDR_PU4:    rdata_next = port_four_pullup_enable_reg;
      mgpp_pkg::ADDR_PORT_TWELVE_PULLUP_ENABLE:   rdata_next = port_twelve_pullup_enable_reg;
      mgpp_pkg::ADDR_ANA2:   rdata_next = port_two_analog_select_reg;
      default:               rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (bus_rd) begin
      rdata_reg <= rdata_next;
    end
  end

  assign bus_rdata = rdata_reg;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  dir_byte_a: assert property (hit(mgpp_pkg::ADDR_DIR4) && !bus_bit_op // R16
    |=> port_four_direction_reg == ($past(bus_wdata) | 8'hC0))
    else $error("direction byte write wrong");
  dir_bit_a: assert property (hit(mgpp_pkg::ADDR_DIR2) && bus_bit_op && bus_bit_idx == 3'h5 // R23
    |=> port_two_direction_reg == $past(port_two_direction_reg))
    else $error("unimplemented direction bit changed");
  oe_mode_a: assert property (p2_pin_oe[0] // R15
    |-> !port_two_direction_reg[0] && !port_two_analog_select_reg[0])
    else $error("buffer on outside output mode");
  pullup_in_a: assert property (p4_pullup[2] // R2
    |-> port_four_direction_reg[2] && port_four_pullup_enable_reg[2])
    else $error("pull-up outside input mode");
  p12_pull_a: assert property (p12_pullup[2:1] == 2'h0) // R9
    else $error("pull-up on wrong port twelve bit");
  osc_own_a: assert property (clk_sel_reg == mgpp_pkg::CLK_XTAL |-> p12_pin_oe[2:1] == 2'h0) // R11
    else $error("oscillator pins driven");
  ext_clk_a: assert property (clk_sel_reg == mgpp_pkg::CLK_EXT && !port_twelve_direction_reg[2] // R12
    |-> !p12_pin_oe[1] && p12_pin_oe[2])
    else $error("external clock pin ownership wrong");
  p13_low_a: assert property (!core_reset_n_reg |=> !output_only_port_bit) // R13
    else $error("output-only bit high during reset");
  hold_rst_a: assert property (state_reg == mgpp_pkg::ST_OPT_WAIT && !rst_pin_sync // R7
    |=> !core_reset_n ##0 state_reg == mgpp_pkg::ST_OPT_WAIT)
    else $error("reset released with pin low");
  port_mode_a: assert property (state_reg == mgpp_pkg::ST_RUN && reset_is_port_reg // R6
    |=> core_reset_n)
    else $error("port-mode pin caused reset");
  irq_edge_a: assert property ($changed(p3_sync[0]) |=> ext_irq_req[0]) // R17
    else $error("missed interrupt pin change");
  read_mix_a: assert property (bus_rd && bus_addr == mgpp_pkg::ADDR_DATA4 // R19
    |=> bus_rdata[5:0] == $past((port_four_direction_reg[5:0] & p4_sync)
                                | (~port_four_direction_reg[5:0] & data4_reg[5:0])))
    else $error("data read mixes wrong");
endmodule : mgpp_ports

//--- tb/mgpp_ext_pins.sv
`timescale 1ns/10ps
module mgpp_ext_pins (
  input  wire logic        clock,
  input  wire logic [14:0] drv_out,
  input  wire logic [14:0] drv_oe,
  input  wire logic [14:0] pull_en,
  input  wire logic [14:0] ext_val,
  input  wire logic [14:0] ext_en,
  output logic      [14:0] pin_lvl
);
  logic tog_reg;

  // Undriven floating lines wander every cycle
  always_ff @(posedge clock) begin
    tog_reg <= (tog_reg !== 1'b1);
  end

  // Chip buffer wins, then the outside driver, then the pull-up
  assign pin_lvl = (drv_oe & drv_out)
                 | (~drv_oe & ext_en & ext_val)
                 | (~drv_oe & ~ext_en & (pull_en | {15{tog_reg}}));
endmodule : mgpp_ext_pins

//--- tb/mgpp_ports_tb.sv
`timescale 1ns/10ps
module mgpp_ports_tb;
  logic        clock;
  logic        rst_n;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata;
  logic        bus_wr;
  logic        bus_rd;
  logic        bus_bit_op;
  logic [2:0]  bus_bit_idx;
  wire  [7:0]  bus_rdata;
  logic        opt_reset_is_port;
  logic [1:0]  opt_clk_sel;
  wire         core_reset_n;
  wire  [14:0] out_v;
  wire  [14:0] oe_v;
  wire  [14:0] pu_v;
  wire  [14:0] lvl_v;
  wire  [3:0]  p2_analog_en;
  wire  [1:0]  osc_mode;
  wire         output_only_port_bit;
  wire  [2:0]  ext_irq_req;
  logic [14:0] ext_val;
  logic [14:0] ext_en;
  logic        reset_shared_pin;
  logic [1:0]  alt3_en;
  logic [1:0]  alt3_val;
  integer      errors = 0;
  integer      n_checks = 0;
  integer      seed = 20987;
  integer      cyc = 0;
  logic [15:0] dir_a [4] = '{mgpp_pkg::ADDR_DIR2, mgpp_pkg::ADDR_DIR3, mgpp_pkg::ADDR_DIR4,
                             mgpp_pkg::ADDR_DIR12};
  logic [15:0] dat_a [4] = '{mgpp_pkg::ADDR_DATA2, mgpp_pkg::ADDR_DATA3, mgpp_pkg::ADDR_DATA4,
                             mgpp_pkg::ADDR_DATA12};
  logic [15:0] pu_a  [4] = '{mgpp_pkg::ADDR_PU2, mgpp_pkg::ADDR_PU3, mgpp_pkg::ADDR_PU4,
                             mgpp_pkg::ADDR_PORT_TWELVE_PULLUP_ENABLE};
  logic [7:0]  mk    [4] = '{8'h0F, 8'h03, 8'h3F, 8'h0E};
  logic [7:0]  pmk   [4] = '{8'h0F, 8'h03, 8'h3F, 8'h08};

  mgpp_ports dut (.clock(clock), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_bit_op(bus_bit_op), .bus_bit_idx(bus_bit_idx),
    .bus_rdata(bus_rdata), .opt_reset_is_port(opt_reset_is_port), .opt_clk_sel(opt_clk_sel),
    .core_reset_n(core_reset_n), .p2_pin_in(lvl_v[3:0]), .p2_pin_out(out_v[3:0]),
    .p2_pin_oe(oe_v[3:0]), .p2_pullup(pu_v[3:0]), .p2_analog_en(p2_analog_en),
    .p3_pin_in(lvl_v[5:4]), .p3_pin_out(out_v[5:4]), .p3_pin_oe(oe_v[5:4]),
    .p3_pullup(pu_v[5:4]), .alt3_en(alt3_en), .alt3_val(alt3_val),
    .p4_pin_in(lvl_v[11:6]),
    .p4_pin_out(out_v[11:6]), .p4_pin_oe(oe_v[11:6]), .p4_pullup(pu_v[11:6]),
    .alt4_en(6'h00), .alt4_val(6'h00), .p12_pin_in(lvl_v[14:12]), .p12_pin_out(out_v[14:12]),
    .p12_pin_oe(oe_v[14:12]), .p12_pullup(pu_v[14:12]), .osc_mode(osc_mode),
    .reset_shared_pin(reset_shared_pin), .output_only_port_bit(output_only_port_bit),
    .ext_irq_req(ext_irq_req));

  mgpp_ext_pins ext (.clock(clock), .drv_out(out_v), .drv_oe(oe_v), .pull_en(pu_v),
    .ext_val(ext_val), .ext_en(ext_en), .pin_lvl(lvl_v));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Register-aligned view of one port out of the packed pin vector
  function automatic logic [7:0] pb(input int k, input logic [14:0] v);
    case (k)
      0: return {4'h0, v[3:0]};
      1: return {6'h00, v[5:4]};
      2: return {2'h0, v[11:6]};
      default: return {4'h0, v[14:12], 1'b0};
    endcase
  endfunction : pb

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic bo,
                    input logic [2:0] bi);
    @(negedge clock);
    bus_addr    = a;
    bus_wdata   = d;
    bus_bit_op  = bo;
    bus_bit_idx = bi;
    bus_wr      = 1'b1;
    @(negedge clock);
    bus_wr = 1'b0;
  endtask : wr

  task automatic rdc(input string nm, input logic [15:0] a, input logic [7:0] exp,
                     input logic [7:0] ck);
    @(negedge clock);
    bus_addr = a;
    bus_rd   = 1'b1;
    @(negedge clock);
    bus_rd = 1'b0;
    chk(nm, exp & ck, bus_rdata & ck);
  endtask : rdc

  task automatic do_reset();
    integer n;
    @(negedge clock);
    rst_n = 1'b0;
    repeat (5) @(negedge clock);
    chk("core reset held", 8'h00, {7'h00, core_reset_n});
    chk("output bit in reset", 8'h00, {7'h00, output_only_port_bit});
    rst_n = 1'b1;
    for (n = 0; n < 8 && core_reset_n !== 1'b1; n++) @(negedge clock);
  endtask : do_reset

  always @(negedge clock) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    integer k, i, n;
    logic [7:0] d, m, pu, en, vv, ck, e;
    rst_n = 1'b0;
    bus_addr = 16'h0000;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_bit_op = 1'b0;
    bus_bit_idx = 3'h0;
    opt_reset_is_port = 1'b0;
    opt_clk_sel = mgpp_pkg::CLK_HSI;
    ext_val = 15'h0000;
    ext_en = 15'h7FFF;
    reset_shared_pin = 1'b1;
    alt3_en = 2'h0;
    alt3_val = 2'h0;
    do_reset();
    for (k = 0; k < 4; k++) begin
      rdc("dir reset", dir_a[k], 8'hFF, 8'hFF);
      chk("oe reset", 8'h00, pb(k, oe_v));
      wr(dir_a[k], 8'h00, 1'b0, 3'h0);
      chk("latch reset", 8'h00, pb(k, out_v) & mk[k]);
      wr(dir_a[k], 8'hFF, 1'b0, 3'h0);
    end
    wr(mgpp_pkg::ADDR_DIR2, 8'h00, 1'b1, 3'h2);
    wr(mgpp_pkg::ADDR_DIR2, 8'h00, 1'b1, 3'h6);
    rdc("dir bit write", mgpp_pkg::ADDR_DIR2, 8'hFB, 8'hFF);
    for (i = 0; i < 20; i++) begin
      for (k = 0; k < 4; k++) begin
        d = 8'($random(seed));
        m = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
        pu = 8'($random(seed));
        ext_val = 15'($random(seed));
        ext_en = 15'($random(seed));
        wr(dat_a[k], d, 1'b0, 3'h0);
        wr(dir_a[k], m, 1'b0, 3'h0);
        wr(pu_a[k], pu, 1'b0, 3'h0);
        repeat (3) @(negedge clock);
        en = pb(k, ext_en);
        vv = pb(k, ext_val);
        ck = mk[k] & (~m | en | (pu & pmk[k]));
        e = (d & ~m) | (m & ((en & vv) | ~en));
        rdc("dir rw", dir_a[k], m | ~mk[k], 8'hFF);
        rdc("data read", dat_a[k], e, ck);
        chk("pin oe", ~m & mk[k], pb(k, oe_v));
        chk("pin out", d & ~m & mk[k], pb(k, out_v) & ~m);
        chk("pullup", pu & pmk[k] & m, pb(k, pu_v));
      end
    end
    wr(mgpp_pkg::ADDR_DIR4, 8'hFF, 1'b0, 3'h0);
    wr(mgpp_pkg::ADDR_DATA4, 8'h2A, 1'b0, 3'h0);
    chk("input mode write", 8'h00, pb(2, oe_v));
    wr(mgpp_pkg::ADDR_DIR4, 8'h00, 1'b0, 3'h0);
    chk("latch kept", 8'h2A, pb(2, out_v));
    wr(mgpp_pkg::ADDR_DIR2, 8'h00, 1'b0, 3'h0);
    wr(mgpp_pkg::ADDR_ANA2, 8'h05, 1'b0, 3'h0);
    chk("analog en", 8'h05, {4'h0, p2_analog_en});
    chk("analog oe", 8'h0A, pb(0, oe_v));
    rdc("analog read", mgpp_pkg::ADDR_DATA2, 8'h00, 8'h05);
    wr(mgpp_pkg::ADDR_ANA2, 8'h00, 1'b0, 3'h0);
    wr(mgpp_pkg::ADDR_DIR3, 8'h00, 1'b0, 3'h0);
    wr(mgpp_pkg::ADDR_DATA3, 8'h00, 1'b0, 3'h0);
    wr(mgpp_pkg::ADDR_DATA4, 8'h00, 1'b0, 3'h0);
    repeat (5) @(negedge clock);
    for (i = 0; i < 3; i++) begin
      wr(i < 2 ? mgpp_pkg::ADDR_DATA3 : mgpp_pkg::ADDR_DATA4,
         (i == 0) ? 8'h01 : (i == 1) ? 8'h02 : 8'h08, 1'b0, 3'h0);
      for (n = 0; n < 6 && ext_irq_req[i] !== 1'b1; n++) @(negedge clock);
      chk("irq on output change", 8'h01, {7'h00, ext_irq_req[i]});
    end
    alt3_en = 2'h2;
    @(negedge clock);
    chk("alt owns pin", 8'h00, pb(1, out_v));
    alt3_en = 2'h0;
    wr(mgpp_pkg::ADDR_DATA13, 8'h01, 1'b0, 3'h0);
    @(negedge clock);
    chk("output only bit", 8'h01, {7'h00, output_only_port_bit});
    for (i = 0; i < 3; i++) begin
      opt_clk_sel = 2'(i);
      do_reset();
      chk("osc mode", 8'(i), {6'h00, osc_mode});
      wr(mgpp_pkg::ADDR_DIR12, 8'h00, 1'b0, 3'h0);
      chk("osc owned oe", {4'h0, 1'b1, i != 1, i == 0, 1'b0}, pb(3, oe_v));
    end
    opt_clk_sel = mgpp_pkg::CLK_HSI;
    opt_reset_is_port = 1'b1;
    do_reset();
    reset_shared_pin = 1'b0;
    repeat (4) @(negedge clock);
    chk("port mode no reset", 8'h01, {7'h00, core_reset_n});
    rdc("shared pin read", mgpp_pkg::ADDR_DATA3, 8'h00, 8'h10);
    reset_shared_pin = 1'b1;
    opt_reset_is_port = 1'b0;
    do_reset();
    wr(mgpp_pkg::ADDR_DATA13, 8'h01, 1'b0, 3'h0);
    reset_shared_pin = 1'b0;
    repeat (4) @(negedge clock);
    chk("pin reset", 8'h00, {7'h00, core_reset_n});
    chk("output bit low", 8'h00, {7'h00, output_only_port_bit});
    rst_n = 1'b0;
    reset_shared_pin = 1'b0;
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    repeat (10) @(negedge clock);
    chk("held by low pin", 8'h00, {7'h00, core_reset_n});
    reset_shared_pin = 1'b1;
    for (n = 0; n < 8 && core_reset_n !== 1'b1; n++) @(negedge clock);
    chk("released by pin", 8'h01, {7'h00, core_reset_n});
    give_verdict();
  end
endmodule : mgpp_ports_tb
